// ==== rtl/uec_defines.svh ====
// Constants of the endpoint-0 control and index block: register indexes,
// field positions and reset values.
// Assumes inclusion by bare name from design modules and the bench.
`ifndef UEC_DEFINES_SVH
`define UEC_DEFINES_SVH

// Register indexes; the Wishbone byte address is four times the index.
`define UEC_IDX_EPIRQ_FLAG   16'hDE02
`define UEC_IDX_EPIRQ_EN     16'hDE07
`define UEC_IDX_FRAME_LOW    16'hDE0C
`define UEC_IDX_FRAME_HIGH   16'hDE0D
`define UEC_IDX_EP_INDEX     16'hDE0E
`define UEC_IDX_IN_MAX       16'hDE10
`define UEC_IDX_EP0_CS       16'hDE11

// Endpoint-0 control and status field positions.
`define UEC_CS_SETUP_CLR     7
`define UEC_CS_RXFLAG_CLR    6
`define UEC_CS_SEND_STALL    5
`define UEC_CS_SETUP_END     4
`define UEC_CS_DATA_END      3
`define UEC_CS_SENT_STALL    2
`define UEC_CS_TX_LOADED     1
`define UEC_CS_RX_WAITING    0

// Interrupt flag and enable position of endpoint 0.
`define UEC_IRQ_EP0_BIT      0

// Reset values.
`define UEC_RST_FRAME        11'h000
`define UEC_RST_INDEX        4'h0
`define UEC_RST_IN_MAX       8'h00
`define UEC_RST_IRQ_EN       1'b1
`define UEC_HIGHEST_EP       4'h5

`endif

// ==== rtl/uec_pkg.sv ====
// Types shared by the endpoint-0 control and index block.
// Assumes uec_defines.svh is on the include path.
package uec_pkg;

    // Register selected by a bus address.
    typedef enum logic [2:0] {
        UEC_REG_NONE  = 3'b000,
        UEC_REG_FLAG  = 3'b001,
        UEC_REG_EN    = 3'b010,
        UEC_REG_FRML  = 3'b011,
        UEC_REG_FRMH  = 3'b100,
        UEC_REG_INDEX = 3'b101,
        UEC_REG_MAXI  = 3'b110,
        UEC_REG_CS0   = 3'b111
    } uec_reg_e;

    typedef logic [10:0] uec_frame_t;
    typedef logic [3:0]  uec_index_t;
    typedef logic [7:0]  uec_byte_t;

endpackage

// ==== rtl/uec_mem_if.sv ====
// Carrier between the register block and its per-endpoint size store.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface uec_mem_if;
    import uec_pkg::*;

    logic        wr_en;
    uec_index_t  addr;
    uec_byte_t   wdata;
    uec_byte_t   rdata;

    modport host  (output wr_en, output addr, output wdata, input rdata);
    modport store (input wr_en, input addr, input wdata, output rdata);
endinterface

// ==== rtl/uec_size_mem.sv ====
// Per-endpoint maximum IN packet size store, one byte per endpoint index.
// Assumes a synchronous active-high reset on the shared clock.
`timescale 1ns/100ps
module uec_size_mem
    import uec_pkg::*;
(
    input wire logic  clk,
    input wire logic  rst,
    uec_mem_if.store  mem
);
    `include "uec_defines.svh"

    uec_byte_t  cell_r [16];

    ////////////////////////////////////////////////////////////////////////
    // Each cell resets to zero and loads on a write to its index.
    genvar g;
    generate
        for (g = 0; g < 16; g++)
        begin : g_cell
            always_ff @(posedge clk)
            begin
                if (rst)
                    cell_r[g] <= `UEC_RST_IN_MAX;
                else if (mem.wr_en && mem.addr == 4'(g))
                    cell_r[g] <= mem.wdata;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data comes out of a register, one cycle behind the address.
    always_ff @(posedge clk)
    begin
        if (rst)
            mem.rdata <= `UEC_RST_IN_MAX;
        else
            mem.rdata <= cell_r[mem.addr];
    end

endmodule

// ==== rtl/uec_ctrl.sv ====
// Endpoint-0 control and status, endpoint index, frame number and IN
// maximum packet size registers of a full-speed USB device controller.
// Assumes a classic Wishbone master and a packet engine on the same clock
// that reports bus events as one-cycle pulses.
//
// What this block does
// R1: Frame number bits 10:8 read-only, reset zero.
// R2: Frame number low byte read-only, reset zero.
// R3: Four-bit endpoint index, software writes 0 to 5.
// R4: Indexed eight-bit IN size, units of eight bytes.
// R5: Software matches size to descriptor and FIFO.
// R6: Endpoint-0 status visible when index is zero.
// R7: Setup-end clear bit drops setup-end, self-clears.
// R8: Receive clear bit drops receive flag, self-clears.
// R9: Stall request ends transaction, hardware clears it.
// R10: Premature end sets setup-end, flushes, interrupts.
// R11: Firmware sets data-end with last packet.
// R12: Hardware clears data-end after data stage.
// R13: Stall sent sets flag, interrupts; firmware clears.
// R14: Transmit-loaded cleared when sent, then interrupts.
// R15: Stored packet sets receive flag, interrupts.
// R16: Endpoint-0 flag sets on request, read clears.
// R17: Enable bit, reset one, gates the interrupt.
// R18: Frame number follows each start-of-frame token.
`timescale 1ns/100ps
module uec_ctrl
    import uec_pkg::*;
(
    input  wire logic         CLK,
    input  wire logic         RST,
    input  wire logic         WB_CYC_I,
    input  wire logic         WB_STB_I,
    input  wire logic         WB_WE_I,
    input  wire logic [17:2]  WB_ADR_I,
    input  wire logic [3:0]   WB_SEL_I,
    input  wire logic [31:0]  WB_DAT_I,
    output      logic [31:0]  WB_DAT_O,
    output      logic         WB_ACK_O,
    input  wire logic         SOF_VALID,
    input  wire logic [10:0]  SOF_FRAME,
    input  wire logic         PREMATURE_END,
    input  wire logic         STALL_SENT,
    input  wire logic         TX_PKT_SENT,
    input  wire logic         RX_PKT_STORED,
    input  wire logic         DATA_STAGE_DONE,
    output      logic         EP0_STALL_REQ,
    output      logic         EP0_TX_READY,
    output      logic         EP0_FIFO_FLUSH,
    output      logic [3:0]   EP_INDEX,
    output      logic [7:0]   EP_IN_MAX,
    output      logic         IRQ
);
    `include "uec_defines.svh"

    ////////////////////////////////////////////////////////////////////////
    // Address decode, shared by the read mux and the write strobes.
    function automatic uec_reg_e uec_decode(input logic [15:0] idx);
        case (idx)
            `UEC_IDX_EPIRQ_FLAG: uec_decode = UEC_REG_FLAG;
            `UEC_IDX_EPIRQ_EN:   uec_decode = UEC_REG_EN;
            `UEC_IDX_FRAME_LOW:  uec_decode = UEC_REG_FRML;
            `UEC_IDX_FRAME_HIGH: uec_decode = UEC_REG_FRMH;
            `UEC_IDX_EP_INDEX:   uec_decode = UEC_REG_INDEX;
            `UEC_IDX_IN_MAX:     uec_decode = UEC_REG_MAXI;
            `UEC_IDX_EP0_CS:     uec_decode = UEC_REG_CS0;
            default:             uec_decode = UEC_REG_NONE;
        endcase
    endfunction

    uec_mem_if  size_bus ();

    logic        ack_r;
    logic [31:0] dat_r;
    uec_frame_t  frame_r;
    uec_index_t  index_r;
    logic        send_stall_r;
    logic        setup_end_r;
    logic        data_end_r;
    logic        sent_stall_r;
    logic        tx_loaded_r;
    logic        rx_waiting_r;
    logic        flush_r;
    logic        ep0_flag_r;
    logic        ep0_en_r;
    logic        flag_shown_r;
    logic        irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Bus phases: a request is taken on the first edge, finished on the
    // edge where the master sees the acknowledge.
    uec_reg_e    sel_reg;
    logic        wb_go;
    logic        wb_fin;
    logic        wr_fin;
    logic        rd_fin;
    logic        lane0;
    uec_byte_t   wbyte;
    assign sel_reg = uec_decode(WB_ADR_I);
    assign wb_go   = WB_CYC_I && WB_STB_I && !ack_r;
    assign wb_fin  = WB_CYC_I && WB_STB_I && ack_r;
    assign lane0   = WB_SEL_I[0];
    assign wbyte   = WB_DAT_I[7:0];
    assign wr_fin  = wb_fin && WB_WE_I && lane0;
    assign rd_fin  = wb_fin && !WB_WE_I;

    // Write strobes per register; status writes need index zero.
    logic        ep0_seen;
    logic        wr_index;
    logic        wr_maxi;
    logic        wr_en_reg;
    logic        wr_cs0;
    logic        rd_flag;
    assign ep0_seen  = (index_r == 4'h0); // [R6]
    assign wr_index  = wr_fin && sel_reg == UEC_REG_INDEX;
    assign wr_maxi   = wr_fin && sel_reg == UEC_REG_MAXI;
    assign wr_en_reg = wr_fin && sel_reg == UEC_REG_EN;
    assign wr_cs0    = wr_fin && sel_reg == UEC_REG_CS0 && ep0_seen; // [R6]
    assign rd_flag   = rd_fin && sel_reg == UEC_REG_FLAG;

    // Individual control bits written to the status register.
    logic        w_setup_clr;
    logic        w_rx_clr;
    logic        w_stall;
    logic        w_data_end;
    logic        w_tx_load;
    assign w_setup_clr = wr_cs0 && wbyte[`UEC_CS_SETUP_CLR];
    assign w_rx_clr    = wr_cs0 && wbyte[`UEC_CS_RXFLAG_CLR];
    assign w_stall     = wr_cs0 && wbyte[`UEC_CS_SEND_STALL];
    assign w_data_end  = wr_cs0 && wbyte[`UEC_CS_DATA_END];
    assign w_tx_load   = wr_cs0 && wbyte[`UEC_CS_TX_LOADED];

    ////////////////////////////////////////////////////////////////////////
    // Next values of the endpoint-0 status bits; hardware events win over
    // software clears, software sets win over hardware clears.
    logic        setup_end_nxt;
    logic        rx_waiting_nxt;
    logic        send_stall_nxt;
    logic        data_end_nxt;
    logic        sent_stall_nxt;
    logic        tx_loaded_nxt;
    logic        ep0_event;
    logic        ep0_flag_nxt;
    logic        ep0_en_nxt;
    assign setup_end_nxt  = PREMATURE_END ||
                            (setup_end_r && !w_setup_clr); // [R7] [R10]
    assign rx_waiting_nxt = RX_PKT_STORED ||
                            (rx_waiting_r && !w_rx_clr);   // [R8] [R15]
    assign send_stall_nxt = w_stall ||
                            (send_stall_r && !STALL_SENT); // [R9]
    assign data_end_nxt   = w_data_end ||
                            (data_end_r && !DATA_STAGE_DONE); // [R12]
    assign sent_stall_nxt = STALL_SENT ||
                            (wr_cs0 ? wbyte[`UEC_CS_SENT_STALL]
                                    : sent_stall_r); // [R13]
    assign tx_loaded_nxt  = w_tx_load ||
                            (tx_loaded_r && !TX_PKT_SENT); // [R14]
    assign ep0_event      = PREMATURE_END || STALL_SENT ||
                            TX_PKT_SENT || RX_PKT_STORED; // [R10] [R13]
    assign ep0_flag_nxt   = ep0_event ||
                            (ep0_flag_r &&
                             !(rd_flag && flag_shown_r)); // [R16]
    assign ep0_en_nxt     = wr_en_reg ? wbyte[`UEC_IRQ_EP0_BIT]
                                      : ep0_en_r; // [R17]

    ////////////////////////////////////////////////////////////////////////
    // Read mux; reserved and unmapped bits read as zero.
    uec_byte_t   cs0_byte;
    uec_byte_t   rd_byte;
    assign cs0_byte = {2'b00, send_stall_r, setup_end_r, data_end_r,
                       sent_stall_r, tx_loaded_r, rx_waiting_r};
    always_comb
    begin
        case (sel_reg)
            UEC_REG_FLAG:  rd_byte = {7'h00, ep0_flag_r};     // [R16]
            UEC_REG_EN:    rd_byte = {7'h00, ep0_en_r};       // [R17]
            UEC_REG_FRML:  rd_byte = frame_r[7:0];            // [R2]
            UEC_REG_FRMH:  rd_byte = {5'h00, frame_r[10:8]};  // [R1]
            UEC_REG_INDEX: rd_byte = {4'h0, index_r};         // [R3]
            UEC_REG_MAXI:  rd_byte = size_bus.rdata;          // [R4]
            UEC_REG_CS0:   rd_byte = ep0_seen ? cs0_byte : 8'h00; // [R6]
            default:       rd_byte = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone answer: acknowledge one cycle after the request is taken,
    // dropped in the cycle after.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ack_r        <= 1'b0;
            dat_r        <= 32'h0000_0000;
            flag_shown_r <= 1'b0;
        end
        else
        begin
            ack_r <= wb_go;
            if (wb_go)
            begin
                dat_r        <= {24'h00_0000, rd_byte};
                flag_shown_r <= ep0_flag_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame number follows each start-of-frame token.
    always_ff @(posedge CLK)
    begin
        if (RST)
            frame_r <= `UEC_RST_FRAME;
        else if (SOF_VALID)
            frame_r <= SOF_FRAME; // [R18] [R1] [R2]
    end

    // Endpoint index register; values above five are the writer's fault.
    always_ff @(posedge CLK)
    begin
        if (RST)
            index_r <= `UEC_RST_INDEX;
        else if (wr_index)
            index_r <= wbyte[3:0]; // [R3]
    end

    ////////////////////////////////////////////////////////////////////////
    // Endpoint-0 status bits, flush pulse, interrupt flag, enable and line.
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            setup_end_r  <= 1'b0;
            rx_waiting_r <= 1'b0;
            send_stall_r <= 1'b0;
            data_end_r   <= 1'b0;
            sent_stall_r <= 1'b0;
            tx_loaded_r  <= 1'b0;
            flush_r      <= 1'b0;
            ep0_flag_r   <= 1'b0;
            ep0_en_r     <= `UEC_RST_IRQ_EN;
            irq_r        <= 1'b0;
        end
        else
        begin
            setup_end_r  <= setup_end_nxt;
            rx_waiting_r <= rx_waiting_nxt;
            send_stall_r <= send_stall_nxt;
            data_end_r   <= data_end_nxt;
            sent_stall_r <= sent_stall_nxt;
            tx_loaded_r  <= tx_loaded_nxt;
            flush_r      <= PREMATURE_END; // [R10]
            ep0_flag_r   <= ep0_flag_nxt;
            ep0_en_r     <= ep0_en_nxt;
            irq_r        <= ep0_flag_nxt && ep0_en_nxt; // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-endpoint IN size store, addressed by the endpoint index.
    assign size_bus.wr_en = wr_maxi; // [R4]
    assign size_bus.addr  = index_r;
    assign size_bus.wdata = wbyte;

    uec_size_mem u_size_mem (
        .clk (CLK),
        .rst (RST),
        .mem (size_bus)
    );

    // Outputs.
    assign WB_DAT_O       = dat_r;
    assign WB_ACK_O       = ack_r;
    assign EP0_STALL_REQ  = send_stall_r; // [R9]
    assign EP0_TX_READY   = tx_loaded_r;
    assign EP0_FIFO_FLUSH = flush_r;
    assign EP_INDEX       = index_r;
    assign EP_IN_MAX      = size_bus.rdata;
    assign IRQ            = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the block's own behaviour.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_frame_follow: assert property ( // [R18]
        SOF_VALID |=> frame_r == $past(SOF_FRAME))
        else $error("frame number did not follow start of frame");

    chk_setup_flush: assert property ( // [R10]
        PREMATURE_END |=> setup_end_r && EP0_FIFO_FLUSH && ep0_flag_r)
        else $error("premature end not flagged with flush");

    chk_setup_clear: assert property ( // [R7]
        w_setup_clr && !PREMATURE_END |=> !setup_end_r ##1 !setup_end_r
            or PREMATURE_END)
        else $error("setup end not cleared by software");

    chk_rxflag_clear: assert property ( // [R8]
        w_rx_clr && !RX_PKT_STORED |=> !rx_waiting_r)
        else $error("receive flag not cleared by software");

    chk_stall_end: assert property ( // [R9]
        STALL_SENT && !w_stall |=> !EP0_STALL_REQ && sent_stall_r)
        else $error("stall request not ended after stall sent");

    chk_data_end_clr: assert property ( // [R12]
        DATA_STAGE_DONE && !w_data_end |=> !data_end_r)
        else $error("data end not cleared after data stage");

    chk_tx_sent: assert property ( // [R14]
        TX_PKT_SENT && !w_tx_load |=> !EP0_TX_READY && ep0_flag_r)
        else $error("transmit flag not cleared with request");

    chk_rx_stored: assert property ( // [R15]
        RX_PKT_STORED |=> rx_waiting_r && ep0_flag_r)
        else $error("stored packet not flagged");

    chk_irq_gate: assert property ( // [R17]
        IRQ == (ep0_flag_r && ep0_en_r))
        else $error("interrupt line disagrees with flag and enable");

    chk_index_load: assert property ( // [R3]
        wr_index |=> EP_INDEX == $past(WB_DAT_I[3:0]))
        else $error("endpoint index not loaded");

    chk_flag_readclr: assert property ( // [R16]
        rd_flag && flag_shown_r && !ep0_event |=> !ep0_flag_r)
        else $error("endpoint flag not cleared by read");

    chk_bus_ack: assert property (
        wb_go |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("acknowledge not a single cycle after request");

    chk_cs0_hidden: assert property ( // [R6]
        wb_go && sel_reg == UEC_REG_CS0 && !ep0_seen |=>
            WB_DAT_O == 32'h0000_0000)
        else $error("endpoint-0 status visible at a nonzero index");

    chk_size_store: assert property ( // [R4]
        wr_maxi |=> ##1 EP_IN_MAX == $past(WB_DAT_I[7:0], 2))
        else $error("IN packet size not stored for the index");

    cov_stall_seq: cover property (w_stall ##[1:20] STALL_SENT);
    cov_premature: cover property (PREMATURE_END && w_setup_clr);
    cov_irq_rise: cover property (!IRQ ##1 IRQ);
    cov_maxi_write: cover property (wr_maxi);

endmodule

// ==== dv/uec_host_model.sv ====
// Behavioural packet engine and USB host beside the endpoint-0 block.
// Assumes the block's clock; the bench calls its tasks for frame, OUT and early-end events.
`timescale 1ns/100ps
module uec_host_model
    import uec_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        stall_req,
    input  wire logic        tx_ready,
    input  wire logic [3:0]  lag,
    output      logic        sof_valid,
    output      uec_frame_t  sof_frame,
    output      logic        early_end,
    output      logic        stall_sent,
    output      logic        tx_sent,
    output      logic        rx_stored,
    output      logic        stage_done
);

    // Idle levels of the event lines commanded by the bench.
    initial
    begin
        sof_valid = 1'b0;
        sof_frame = 11'h000;
        early_end = 1'b0;
        rx_stored = 1'b0;
    end

    // One start-of-frame token; the frame bus shows garbage outside it.
    task pulse_sof(input uec_frame_t f);
        @(posedge clk);
        sof_valid <= 1'b1;
        sof_frame <= f;
        @(posedge clk);
        sof_valid <= 1'b0;
        sof_frame <= ~f;
    endtask

    // One-cycle event: 0 stores an OUT packet, 1 ends a transfer early.
    task pulse(input int k);
        @(posedge clk);
        if (k == 0)
            rx_stored <= 1'b1;
        else
            early_end <= 1'b1;
        @(posedge clk);
        rx_stored <= 1'b0;
        early_end <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Answers a stall request after lag cycles with one STALL handshake.
    initial
    begin
        stall_sent = 1'b0;
        forever
        begin
            @(posedge clk);
            if (stall_req === 1'b1 && rst === 1'b0)
            begin
                repeat (lag) @(posedge clk);
                stall_sent <= 1'b1;
                @(posedge clk);
                stall_sent <= 1'b0;
                @(posedge clk);
            end
        end
    end

    // Sends a loaded IN packet, then closes the control data stage.
    initial
    begin
        tx_sent = 1'b0;
        stage_done = 1'b0;
        forever
        begin
            @(posedge clk);
            if (tx_ready === 1'b1 && rst === 1'b0)
            begin
                repeat (lag) @(posedge clk);
                tx_sent <= 1'b1;
                @(posedge clk);
                tx_sent <= 1'b0;
                stage_done <= 1'b1;
                @(posedge clk);
                stage_done <= 1'b0;
                @(posedge clk);
            end
        end
    end
endmodule

// ==== dv/tb_uec_ctrl.sv ====
// Self-checking bench of the endpoint-0 control and index block.
// Assumes uec_defines.svh on the include path and the host model beside.
`timescale 1ns/100ps
`include "uec_defines.svh"
module tb_uec_ctrl
    import uec_pkg::*;
;
    typedef struct {logic we; logic [15:0] a; uec_byte_t d;} uec_row_s;

    logic        clk = 1'b0;
    logic        rst, cyc, stb, we, ack, irq, flush, stall_req, tx_ready;
    logic [17:2] adr;
    logic [31:0] dat_i, dat_o;
    logic        sof_v, early, st_sent, tx_sent, rx_st, done;
    uec_frame_t  sof_f;
    uec_index_t  ep_index;
    uec_byte_t   ep_in_max, q;
    logic [3:0]  lag, sel, wsel;
    int          fails = 0;
    int          n_checks = 0;

    // Writes carry data, reads carry the expected byte.
    uec_row_s rows [22] = '{
        '{1'b0, `UEC_IDX_FRAME_LOW, 8'h00}, '{1'b0, `UEC_IDX_FRAME_HIGH, 8'h00},
        '{1'b0, `UEC_IDX_EP_INDEX, 8'h00}, '{1'b0, `UEC_IDX_IN_MAX, 8'h00},
        '{1'b0, `UEC_IDX_EP0_CS, 8'h00}, '{1'b0, `UEC_IDX_EPIRQ_EN, 8'h01},
        '{1'b0, `UEC_IDX_EPIRQ_FLAG, 8'h00}, '{1'b1, `UEC_IDX_FRAME_HIGH, 8'hFF},
        '{1'b0, `UEC_IDX_FRAME_HIGH, 8'h00}, '{1'b1, `UEC_IDX_EP_INDEX, 8'hF3},
        '{1'b0, `UEC_IDX_EP_INDEX, 8'h03}, '{1'b1, `UEC_IDX_IN_MAX, 8'h08},
        '{1'b1, `UEC_IDX_EP0_CS, 8'h22}, '{1'b0, `UEC_IDX_EP0_CS, 8'h00},
        '{1'b1, `UEC_IDX_EP_INDEX, 8'h05}, '{1'b1, `UEC_IDX_IN_MAX, 8'h40},
        '{1'b1, `UEC_IDX_EP_INDEX, 8'h03}, '{1'b0, `UEC_IDX_IN_MAX, 8'h08},
        '{1'b1, `UEC_IDX_EP_INDEX, 8'h00}, '{1'b0, `UEC_IDX_EP0_CS, 8'h00},
        '{1'b0, `UEC_IDX_IN_MAX, 8'h00}, '{1'b0, 16'hDE01, 8'h00}};

    // The clock runs at 25 MHz.
    always #20 clk = ~clk;

    uec_ctrl u_uec_ctrl (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SOF_VALID(sof_v),
        .SOF_FRAME(sof_f), .PREMATURE_END(early), .STALL_SENT(st_sent),
        .TX_PKT_SENT(tx_sent), .RX_PKT_STORED(rx_st), .DATA_STAGE_DONE(done),
        .EP0_STALL_REQ(stall_req), .EP0_TX_READY(tx_ready),
        .EP0_FIFO_FLUSH(flush), .EP_INDEX(ep_index), .EP_IN_MAX(ep_in_max),
        .IRQ(irq));

    uec_host_model u_uec_host_model (.clk(clk), .rst(rst),
        .stall_req(stall_req), .tx_ready(tx_ready), .lag(lag),
        .sof_valid(sof_v), .sof_frame(sof_f), .early_end(early),
        .stall_sent(st_sent), .tx_sent(tx_sent), .rx_stored(rx_st),
        .stage_done(done));

    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Counts one comparison and reports a mismatch.
    task chk(input string nm, input uec_byte_t e, input uec_byte_t g);
        n_checks = n_checks + 1;
        if (g !== e)
        begin
            fails = fails + 1;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled high.
    task wb(input logic w, input logic [15:0] a, input uec_byte_t d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= wsel;
        adr <= a;
        dat_i <= {24'h0, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n = n + 1;
        end
        while (ack !== 1'b1 && n < 20);
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1)
        begin
            chk("ack", 8'h01, {7'h0, ack});
            test_done();
        end
    endtask

    // Reads a register and compares the byte.
    task rd_chk(input logic [15:0] a, input uec_byte_t e);
        wb(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), e, q);
    endtask

    // Waits, bounded, for the stall request or the tx flag to drop.
    task wait_low(input logic tx);
        int n;
        n = 0;
        while ((tx ? tx_ready : stall_req) !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            n = n + 1;
        end
        chk("ep0 handshake", 8'h00, {7'h0, tx ? tx_ready : stall_req});
        if (n == 100)
            test_done();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Reset, the row table, then the event scenarios.
    initial
    begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 16'h0000;
        dat_i = 32'h0;
        lag = 4'h0;
        sel = 4'h0;
        wsel = 4'hF;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
            if (rows[i].we)
                wb(1'b1, rows[i].a, rows[i].d);
            else
                rd_chk(rows[i].a, rows[i].d);
        u_uec_host_model.pulse_sof(11'h5A3);
        rd_chk(`UEC_IDX_FRAME_LOW, 8'hA3);
        rd_chk(`UEC_IDX_FRAME_HIGH, 8'h05);
        u_uec_host_model.pulse(0);
        repeat (2) @(posedge clk);
        chk("irq", 8'h01, {7'h0, irq});
        rd_chk(`UEC_IDX_EP0_CS, 8'h01);
        rd_chk(`UEC_IDX_EPIRQ_FLAG, 8'h01);
        rd_chk(`UEC_IDX_EPIRQ_FLAG, 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        wb(1'b1, `UEC_IDX_EP0_CS, 8'h40);
        rd_chk(`UEC_IDX_EP0_CS, 8'h00);
        u_uec_host_model.pulse(1);
        @(posedge clk);
        chk("flush", 8'h01, {7'h0, flush});
        rd_chk(`UEC_IDX_EP0_CS, 8'h10);
        rd_chk(`UEC_IDX_EPIRQ_FLAG, 8'h01);
        wb(1'b1, `UEC_IDX_EP0_CS, 8'h80);
        rd_chk(`UEC_IDX_EP0_CS, 8'h00);
        // A slow host answers the stall request.
        lag <= 4'h5;
        wb(1'b1, `UEC_IDX_EP0_CS, 8'h20);
        @(posedge clk);
        chk("stall req", 8'h01, {7'h0, stall_req});
        wait_low(1'b0);
        rd_chk(`UEC_IDX_EP0_CS, 8'h04);
        rd_chk(`UEC_IDX_EPIRQ_FLAG, 8'h01);
        wb(1'b1, `UEC_IDX_EP0_CS, 8'h00);
        rd_chk(`UEC_IDX_EP0_CS, 8'h00);
        // A prompt host takes the last IN packet with data end.
        lag <= 4'h0;
        wb(1'b1, `UEC_IDX_EP0_CS, 8'h0A);
        @(posedge clk);
        chk("tx ready", 8'h01, {7'h0, tx_ready});
        wait_low(1'b1);
        repeat (3) @(posedge clk);
        rd_chk(`UEC_IDX_EP0_CS, 8'h00);
        rd_chk(`UEC_IDX_EPIRQ_FLAG, 8'h01);
        // The mask holds the output low until enabled again.
        wb(1'b1, `UEC_IDX_EPIRQ_EN, 8'h00);
        u_uec_host_model.pulse(0);
        repeat (2) @(posedge clk);
        chk("irq", 8'h00, {7'h0, irq});
        wb(1'b1, `UEC_IDX_EPIRQ_EN, 8'h01);
        repeat (2) @(posedge clk);
        chk("irq", 8'h01, {7'h0, irq});
        rd_chk(`UEC_IDX_EPIRQ_FLAG, 8'h01);
        wb(1'b1, `UEC_IDX_EP0_CS, 8'h40);
        // Index 3 drives the index and IN size outputs.
        wb(1'b1, `UEC_IDX_EP_INDEX, 8'h03);
        repeat (2) @(posedge clk);
        chk("EP_INDEX", 8'h03, {4'h0, ep_index});
        chk("EP_IN_MAX", 8'h08, ep_in_max);
        // A write without byte lane 0 leaves the index alone.
        wsel = 4'hE;
        wb(1'b1, `UEC_IDX_EP_INDEX, 8'h05);
        wsel = 4'hF;
        rd_chk(`UEC_IDX_EP_INDEX, 8'h03);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`UEC_IDX_EP_INDEX, 8'h00);
        rd_chk(`UEC_IDX_EPIRQ_EN, 8'h01);
        rd_chk(`UEC_IDX_FRAME_LOW, 8'h00);
        test_done();
    end
endmodule
